// ### src/core_regs_pkg.sv
/*
 * constants and carrier types for the cpu core special register bank
 * assumes a single 10 MHz core clock and a synchronous active-high reset
 */
package core_regs_pkg;

	// ****************************************************************
	// register space addresses
	// ****************************************************************
	localparam logic [7:0] ADDR_STACK_PTR = 8'h81;
	localparam logic [7:0] ADDR_PTR_LOW = 8'h82;
	localparam logic [7:0] ADDR_PTR_HIGH = 8'h83;
	localparam logic [7:0] ADDR_PTR_PAGE = 8'h84;
	localparam logic [7:0] ADDR_POWER_CTL = 8'h87;
	localparam logic [7:0] ADDR_STATUS_WORD = 8'hD0;
	localparam logic [7:0] ADDR_ACCUM = 8'hE0;
	localparam logic [7:0] ADDR_MULDIV = 8'hF0;
	localparam logic [7:0] SPACE_BASE = 8'h80;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [7:0] RST_STACK_PTR = 8'h07;
	localparam logic [7:0] RST_ZERO = 8'h00;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int SW_CARRY = 7;
	localparam int SW_HALF_CARRY = 6;
	localparam int SW_USER_A = 5;
	localparam int SW_BANK_HI = 4;
	localparam int SW_BANK_LO = 3;
	localparam int SW_OVERFLOW = 2;
	localparam int SW_USER_B = 1;
	localparam int SW_PARITY = 0;
	localparam int PC_BAUD_DOUBLER = 7;
	localparam int PC_LATCH_OFF = 4;
	localparam int PC_GEN_B = 3;
	localparam int PC_GEN_A = 2;
	localparam int PC_POWER_DOWN = 1;
	localparam int PC_IDLE = 0;
	localparam logic [7:0] PC_WRITE_MASK = 8'h9F;
	localparam logic [3:0] BIT_NIBBLE_A = 4'h0;
	localparam logic [3:0] BIT_NIBBLE_B = 4'h8;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ****************************************************************
	// carrier types
	// ****************************************************************
	typedef enum logic [1:0] {ALU_NONE, ALU_ACC_ONLY, ALU_ACC_AUX} alu_wr_t;

	// flag updates from the execution unit
	typedef struct packed {
		logic carryWe;
		logic carry;
		logic halfCarryWe;
		logic halfCarry;
		logic overflowWe;
		logic overflow;
	} flag_upd_t;

	// register space access from the core
	typedef struct packed {
		logic wr;
		logic rd;
		logic bitOp;
		logic [2:0] bitSel;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

	// decoded power control bits
	typedef struct packed {
		logic baudDoubler;
		logic latchStrobeDisable;
		logic generalFlagB;
		logic generalFlagA;
		logic powerDownEnable;
		logic idleEnable;
	} power_bits_t;

	// all state of the bank
	typedef struct packed {
		logic [7:0] accumReg;
		logic [7:0] auxReg;
		logic [7:0] stackPtr;
		logic [7:0] pointerPageByte;
		logic [7:0] pointerHighByte;
		logic [7:0] pointerLowByte;
		logic [7:0] statusWord;
		logic [7:0] powerCtlReg;
		logic [7:0] rdata;
		logic rvalid;
	} bank_state_t;

endpackage

// ### src/sfr_addr_decode.sv
/*
 * address decode for the special register space
 * assumes addresses come from direct addressing only; indirect accesses never reach here
 */
`timescale 1ns/100ps
module sfr_addr_decode
(
	input wire logic [7:0] addr,
	output logic [7:0] hit,
	output logic inSpace,
	output logic bitCapable
);
	localparam logic [7:0] MAP [8] = '{core_regs_pkg::ADDR_ACCUM, core_regs_pkg::ADDR_MULDIV,
		core_regs_pkg::ADDR_STACK_PTR, core_regs_pkg::ADDR_PTR_PAGE, core_regs_pkg::ADDR_PTR_HIGH,
		core_regs_pkg::ADDR_PTR_LOW, core_regs_pkg::ADDR_STATUS_WORD, core_regs_pkg::ADDR_POWER_CTL};

	// ****************************************************************
	// one comparator per implemented register
	// ****************************************************************
	genvar i;
	generate
		for (i = 0; i < 8; i++)
		begin : g_hit
			assign hit[i] = inSpace && (addr == MAP[i]); // RQ12
		end
	endgenerate

	// upper half of data memory only
	assign inSpace = addr[7]; // RQ14
	// bit access only where the low nibble is 0 or 8
	assign bitCapable = inSpace && ((addr[3:0] == core_regs_pkg::BIT_NIBBLE_A)
		|| (addr[3:0] == core_regs_pkg::BIT_NIBBLE_B)); // RQ11
endmodule

// ### src/cpu_core_special_registers.sv
/*
 * cpu core special register bank: accumulator, multiply/divide operand, stack pointer,
 * three-byte data pointer, status word and power control, with register space decode
 * assumes the core sequences its own accesses: one request per cycle, read data next cycle
 */
//
// Function
// RQ1: accumulator is operand and result for arithmetic, multiply, divide and bit operations.
// RQ2: auxiliary byte pairs with accumulator for multiply/divide, else plain scratch byte.
// RQ3: push or call increments stack pointer first, then writes RAM at new address.
// RQ4: reset loads stack pointer with 07H so first push lands at 08H.
// RQ5: data pointer is page, high and low bytes giving 24-bit address.
// RQ6: pointer increment carries out of high byte into page byte.
// RQ7: each pointer byte is read and written alone at its own address.
// RQ8: status word bits: carry 7, half carry 6, flags 5 and 1, overflow 2, parity 0.
// RQ9: status bits 4 and 3 select one of four working register banks.
// RQ10: power control: baud doubler, latch strobe off, two flags, power-down, idle.
// RQ11: only addresses ending 0H or 8H allow single-bit access.
// RQ12: unoccupied addresses hold nothing; writes vanish, reads return anything.
// RQ13: every register but program counter and banks sits in register space.
// RQ14: register space is upper 128 bytes, reached only by direct addressing.
// RQ15: parity bit always equals XOR of all accumulator bits.
// RQ16: reserved power control bits ignore writes and read as zero.
`timescale 1ns/100ps
module cpu_core_special_registers
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire core_regs_pkg::sfr_req_t sfrReq,
	output logic [7:0] sfrRdata,
	output logic sfrRvalid,
	output logic sfrBitCapable,
	input wire core_regs_pkg::alu_wr_t aluWr,
	input wire logic [7:0] aluAccum,
	input wire logic [7:0] aluAux,
	input wire core_regs_pkg::flag_upd_t flagUpd,
	input wire logic stackPush,
	input wire logic stackPop,
	input wire logic pointerInc,
	output logic [7:0] stackWrAddr,
	output logic [7:0] accumReg,
	output logic [7:0] auxReg,
	output logic [7:0] stackPtr,
	output logic [23:0] pointerWord,
	output logic [7:0] statusWord,
	output logic [1:0] bankSelect,
	output logic [4:0] bankBase,
	output core_regs_pkg::power_bits_t powerBits
);
	core_regs_pkg::bank_state_t state_r;
	core_regs_pkg::bank_state_t state_nxt;
	logic [7:0] hit;
	logic inSpace;
	logic bitCapable;
	logic [7:0] curVal;
	logic [7:0] newVal;
	logic [16:0] incSum;
	logic parityNow;

	// ****************************************************************
	// address decode
	// ****************************************************************
	// hit order: accum, aux, stack, page, high, low, status, power
	sfr_addr_decode u_decode
	(
		.addr(sfrReq.addr),
		.hit(hit),
		.inSpace(inSpace),
		.bitCapable(bitCapable)
	);

	// ****************************************************************
	// current value of the addressed register
	// ****************************************************************
	// unoccupied locations read a fixed value, which is allowed to be anything
	always_comb
	begin
		unique case (1'b1)
			hit[0]: curVal = state_r.accumReg;
			hit[1]: curVal = state_r.auxReg;
			hit[2]: curVal = state_r.stackPtr;
			hit[3]: curVal = state_r.pointerPageByte;
			hit[4]: curVal = state_r.pointerHighByte;
			hit[5]: curVal = state_r.pointerLowByte;
			hit[6]: curVal = {state_r.statusWord[7:1], parityNow};
			hit[7]: curVal = state_r.powerCtlReg & core_regs_pkg::PC_WRITE_MASK; // RQ16
			default: curVal = core_regs_pkg::UNMAPPED_READ; // RQ12
		endcase
	end

	// bit writes merge one bit into the current byte, only where the address allows it
	always_comb
	begin
		newVal = sfrReq.wdata;
		if (sfrReq.bitOp)
		begin
			newVal = curVal;
			newVal[sfrReq.bitSel] = sfrReq.wdata[0]; // RQ11
		end
	end

	// parity tracks the accumulator currently stored
	assign parityNow = ^state_r.accumReg; // RQ15
	// 16-bit increment of high:low, carry out feeds the page byte
	assign incSum = {1'b0, state_r.pointerHighByte, state_r.pointerLowByte} + 17'h00001;

	// ****************************************************************
	// next state
	// ****************************************************************
	// software writes are applied before the core's own updates so execution results win
	always_comb
	begin
		logic sfrWrOk;
		sfrWrOk = sfrReq.wr && inSpace && (!sfrReq.bitOp || bitCapable); // RQ14 RQ11
		state_nxt = state_r;
		state_nxt.rvalid = 1'b0;
		state_nxt.rdata = state_r.rdata;

		// register space writes, each byte on its own address
		if (sfrWrOk)
		begin
			if (hit[0])
				state_nxt.accumReg = newVal;
			if (hit[1])
				state_nxt.auxReg = newVal; // RQ2
			if (hit[2])
				state_nxt.stackPtr = newVal; // RQ4
			if (hit[3])
				state_nxt.pointerPageByte = newVal; // RQ7
			if (hit[4])
				state_nxt.pointerHighByte = newVal; // RQ7
			if (hit[5])
				state_nxt.pointerLowByte = newVal; // RQ7
			if (hit[6])
				state_nxt.statusWord = newVal; // RQ8 RQ9
			if (hit[7])
				state_nxt.powerCtlReg = newVal & core_regs_pkg::PC_WRITE_MASK; // RQ10 RQ16
		end

		// reads: registered data one cycle after the request
		if (sfrReq.rd)
		begin
			state_nxt.rvalid = 1'b1;
			state_nxt.rdata = (inSpace && (!sfrReq.bitOp || bitCapable)) ? curVal
				: core_regs_pkg::UNMAPPED_READ; // RQ14
		end

		// execution results into accumulator and, for multiply/divide, the aux byte
		case (aluWr)
			core_regs_pkg::ALU_ACC_ONLY:
			begin
				state_nxt.accumReg = aluAccum; // RQ1
			end
			core_regs_pkg::ALU_ACC_AUX:
			begin
				state_nxt.accumReg = aluAccum; // RQ1
				state_nxt.auxReg = aluAux; // RQ2
			end
			default:
			begin
				state_nxt.accumReg = state_nxt.accumReg;
			end
		endcase

		// flag updates from the execution unit
		if (flagUpd.carryWe)
			state_nxt.statusWord[core_regs_pkg::SW_CARRY] = flagUpd.carry; // RQ8
		if (flagUpd.halfCarryWe)
			state_nxt.statusWord[core_regs_pkg::SW_HALF_CARRY] = flagUpd.halfCarry; // RQ8
		if (flagUpd.overflowWe)
			state_nxt.statusWord[core_regs_pkg::SW_OVERFLOW] = flagUpd.overflow; // RQ8

		// stack: increment first, the write address is the new value
		if (stackPush)
			state_nxt.stackPtr = state_r.stackPtr + 8'h01; // RQ3
		else if (stackPop)
			state_nxt.stackPtr = state_r.stackPtr - 8'h01;

		// pointer increment spans all three bytes
		if (pointerInc)
		begin
			state_nxt.pointerLowByte = incSum[7:0];
			state_nxt.pointerHighByte = incSum[15:8];
			state_nxt.pointerPageByte = state_r.pointerPageByte + {7'h00, incSum[16]}; // RQ6
		end

		// parity is stored alongside so the register image is always consistent
		state_nxt.statusWord[core_regs_pkg::SW_PARITY] = ^state_nxt.accumReg; // RQ15
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			state_r <= '0;
			state_r.stackPtr <= core_regs_pkg::RST_STACK_PTR; // RQ4
		end
		else
			state_r <= state_nxt;
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	// push address is the incremented pointer, so the first push after reset is 08H
	assign stackWrAddr = state_r.stackPtr + 8'h01; // RQ3
	assign sfrRdata = state_r.rdata;
	assign sfrRvalid = state_r.rvalid;
	assign sfrBitCapable = bitCapable; // RQ11
	assign accumReg = state_r.accumReg; // RQ1
	assign auxReg = state_r.auxReg;
	assign stackPtr = state_r.stackPtr;
	assign pointerWord = {state_r.pointerPageByte, state_r.pointerHighByte, state_r.pointerLowByte}; // RQ5
	assign statusWord = {state_r.statusWord[7:1], parityNow}; // RQ15
	assign bankSelect = {state_r.statusWord[core_regs_pkg::SW_BANK_HI],
		state_r.statusWord[core_regs_pkg::SW_BANK_LO]}; // RQ9
	// each bank is eight bytes in low RAM
	assign bankBase = {bankSelect, 3'b000}; // RQ9
	// all core registers live in the space above; nothing else is stored here (RQ13 by construction)
	assign powerBits.baudDoubler = state_r.powerCtlReg[core_regs_pkg::PC_BAUD_DOUBLER]; // RQ10
	assign powerBits.latchStrobeDisable = state_r.powerCtlReg[core_regs_pkg::PC_LATCH_OFF]; // RQ10
	assign powerBits.generalFlagB = state_r.powerCtlReg[core_regs_pkg::PC_GEN_B];
	assign powerBits.generalFlagA = state_r.powerCtlReg[core_regs_pkg::PC_GEN_A];
	assign powerBits.powerDownEnable = state_r.powerCtlReg[core_regs_pkg::PC_POWER_DOWN]; // RQ10
	assign powerBits.idleEnable = state_r.powerCtlReg[core_regs_pkg::PC_IDLE]; // RQ10
endmodule

// ### test/cpu_core_special_registers_assertions.sv
/* concurrent checks for the core register bank
 bound to cpu_core_special_registers; sees only its ports */
`timescale 1ns/100ps
module cpu_core_special_registers_assertions
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire core_regs_pkg::sfr_req_t sfrReq,
	input wire logic [7:0] sfrRdata,
	input wire logic sfrRvalid,
	input wire logic sfrBitCapable,
	input wire core_regs_pkg::alu_wr_t aluWr,
	input wire logic [7:0] aluAccum,
	input wire logic [7:0] aluAux,
	input wire core_regs_pkg::flag_upd_t flagUpd,
	input wire logic stackPush,
	input wire logic stackPop,
	input wire logic pointerInc,
	input wire logic [7:0] stackWrAddr,
	input wire logic [7:0] accumReg,
	input wire logic [7:0] auxReg,
	input wire logic [7:0] stackPtr,
	input wire logic [23:0] pointerWord,
	input wire logic [7:0] statusWord,
	input wire logic [1:0] bankSelect,
	input wire logic [4:0] bankBase,
	input wire core_regs_pkg::power_bits_t powerBits
);
	// one clock domain, so clocking and reset are given once
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	AST_SP_RST: assert property ($fell(sys_rst) |-> stackPtr == 8'h07) else $error("stack pointer reset");
	AST_PUSH: assert property (stackPush |-> stackWrAddr == stackPtr + 8'h01 ##1 stackPtr == $past(stackWrAddr))
		else $error("push order");
	AST_PARITY: assert property (statusWord[0] == ^accumReg) else $error("parity");
	AST_BANK: assert property (bankSelect == statusWord[4:3] && bankBase == {statusWord[4:3], 3'h0})
		else $error("bank select");
	AST_INC: assert property (pointerInc |=> pointerWord == $past(pointerWord) + 24'h000001)
		else $error("pointer carry");
	AST_PTR_RD: assert property (sfrReq.rd && sfrReq.addr == 8'h82 && !sfrReq.bitOp
		|=> sfrRvalid && sfrRdata == $past(pointerWord[7:0]))
		else $error("pointer byte read");
	AST_PC_RSV: assert property (sfrReq.rd && sfrReq.addr == 8'h87 && !sfrReq.bitOp
		|=> sfrRdata == {$past(powerBits[5]), 2'h0, $past(powerBits[4:0])}) else $error("power read");
	// a write below the space must leave the stack pointer, data pointer and aux byte alone
	AST_LOW_WR: assert property (sfrReq.wr && !sfrReq.addr[7] && aluWr == core_regs_pkg::ALU_NONE && !stackPush
		&& !stackPop && !pointerInc |=> $stable(stackPtr) && $stable(pointerWord) && $stable(auxReg))
		else $error("low write");
	AST_BITCAP: assert property (sfrBitCapable == (sfrReq.addr[7] && sfrReq.addr[2:0] == 3'h0))
		else $error("bit capable");
	AST_ALU: assert property (aluWr == core_regs_pkg::ALU_ACC_AUX |=> accumReg == $past(aluAccum)
		&& auxReg == $past(aluAux)) else $error("alu write");
	cover property (stackPush);
	cover property (pointerInc && pointerWord[15:0] == 16'hFFFF);
	cover property (sfrReq.rd && sfrReq.addr == 8'h87);
endmodule

bind cpu_core_special_registers cpu_core_special_registers_assertions chk (.*);

// ### test/cpu_core_special_registers_tb.sv
/* self-checking bench for the core register bank
 drives every input itself; an integer model predicts each result */
`timescale 1ns/100ps
module cpu_core_special_registers_tb;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	core_regs_pkg::sfr_req_t sfrReq = '0;
	core_regs_pkg::alu_wr_t aluWr = core_regs_pkg::ALU_NONE;
	core_regs_pkg::flag_upd_t flagUpd = '0;
	logic [7:0] aluAccum = 8'h00;
	logic [7:0] aluAux = 8'h00;
	logic stackPush = 1'b0;
	logic stackPop = 1'b0;
	logic pointerInc = 1'b0;
	logic [7:0] sfrRdata, stackWrAddr, accumReg, auxReg, stackPtr, statusWord, d;
	logic sfrRvalid, sfrBitCapable;
	logic [23:0] pointerWord;
	logic [1:0] bankSelect;
	logic [4:0] bankBase;
	core_regs_pkg::power_bits_t powerBits;
	int numErrors = 0;
	int nChecks = 0;
	int cyc = 0;
	int seed = 32'h34C57B50;
	int mdl[8] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] adr[8] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h87, 8'hD0, 8'hE0, 8'hF0};

	cpu_core_special_registers DUT (.*);

	always #50 ref_clk = ~ref_clk;

	task automatic chk(input logic [23:0] s, input logic [23:0] e);
		nChecks++;
		if (s !== e)
		begin
			numErrors++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	// the stored parity bit is ignored: the model derives it from the accumulator
	function automatic logic [7:0] expv(input int i);
		logic [7:0] v;
		v = mdl[i];
		if (i == 5)
			v[0] = ^mdl[6][7:0];
		return v;
	endfunction

	task automatic wr(input logic [7:0] a, input logic [7:0] w, input logic b, input logic [2:0] s);
		@(posedge ref_clk);
		sfrReq <= '{1'b1, 1'b0, b, s, a, w};
		@(posedge ref_clk);
		sfrReq <= '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		sfrReq <= '{1'b0, 1'b1, 1'b0, 3'h0, a, 8'h00};
		@(posedge ref_clk);
		chk(sfrBitCapable, a[7] && a[2:0] == 3'h0);
		sfrReq <= '0;
		#1;
		chk({sfrRvalid, sfrRdata}, {1'b1, e});
	endtask

	// one core cycle; the model follows it afterwards
	task automatic core(input logic p, input logic n, input core_regs_pkg::alu_wr_t w,
		input core_regs_pkg::flag_upd_t g);
		logic [23:0] v;
		@(posedge ref_clk);
		stackPush <= p;
		pointerInc <= n;
		aluWr <= w;
		flagUpd <= g;
		aluAccum <= 8'($random(seed));
		aluAux <= 8'($random(seed));
		@(posedge ref_clk);
		stackPush <= 1'b0;
		pointerInc <= 1'b0;
		aluWr <= core_regs_pkg::ALU_NONE;
		flagUpd <= '0;
		#1;
		mdl[0] = (mdl[0] + p) & 8'hFF;
		v = {mdl[3][7:0], mdl[2][7:0], mdl[1][7:0]} + n;
		mdl[3] = v[23:16];
		mdl[2] = v[15:8];
		mdl[1] = v[7:0];
		if (w != core_regs_pkg::ALU_NONE)
			mdl[6] = aluAccum;
		if (w == core_regs_pkg::ALU_ACC_AUX)
			mdl[7] = aluAux;
		if (g.carryWe)
			mdl[5][7] = g.carry;
		if (g.halfCarryWe)
			mdl[5][6] = g.halfCarry;
		if (g.overflowWe)
			mdl[5][2] = g.overflow;
	endtask

	task automatic printVerdict;
		if (numErrors == 0 && nChecks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// hang guard: the whole sequence needs about a hundred cycles
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			numErrors++;
			printVerdict;
		end
	end

	initial
	begin
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 8; i++)
			rd(adr[i], expv(i));
		for (int i = 0; i < 8; i++)
		begin
			d = $random(seed);
			wr(adr[i], d, 1'b0, 3'h0);
			mdl[i] = (i == 4) ? d & 8'h9F : d;
		end
		wr(8'h85, d, 1'b0, 3'h0);
		wr(8'h30, d, 1'b0, 3'h0);
		rd(8'h85, 8'h00);
		chk({bankSelect, bankBase}, {mdl[5][4:3], mdl[5][4:3], 3'h0});
		chk(powerBits, {mdl[4][7], mdl[4][4:0]});
		chk(stackWrAddr, 8'(mdl[0] + 1));
		core(1'b1, 1'b0, core_regs_pkg::ALU_NONE, '0);
		chk(stackPtr, mdl[0]);
		// pop walks the pointer back down by one
		@(posedge ref_clk);
		stackPop <= 1'b1;
		@(posedge ref_clk);
		stackPop <= 1'b0;
		#1;
		mdl[0] = (mdl[0] + 255) & 8'hFF;
		chk(stackPtr, mdl[0]);
		wr(8'h82, 8'hFF, 1'b0, 3'h0);
		wr(8'h83, 8'hFF, 1'b0, 3'h0);
		mdl[1] = 8'hFF;
		mdl[2] = 8'hFF;
		core(1'b0, 1'b1, core_regs_pkg::ALU_NONE, '0);
		chk(pointerWord, {mdl[3][7:0], mdl[2][7:0], mdl[1][7:0]});
		for (int k = 0; k < 6; k++)
		begin
			core(1'b0, 1'b0, core_regs_pkg::alu_wr_t'(2'(k % 3)), core_regs_pkg::flag_upd_t'(6'($random(seed))));
			chk({accumReg, auxReg}, {mdl[6][7:0], mdl[7][7:0]});
			chk(statusWord, expv(5));
		end
		d = $random(seed);
		wr(8'hD0, d, 1'b1, 3'h5);
		mdl[5][5] = d[0];
		wr(8'h81, 8'hFF, 1'b1, 3'h0);
		for (int i = 0; i < 8; i++)
			rd(adr[i], expv(i));
		printVerdict;
	end
endmodule
